// ===== rtl/iocss_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
`include "iocss_defs.svh"

module iocss_sequencer
  import iocss_pkg::*;
#(
  // control identification; value is arbitrary
  parameter logic [5:0] CTRL_ID = 6'h2A
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`IOCSS_BUS_W-1:0] exchange_bus_line_in,
  input wire logic phase_a,
  input wire logic phase_b,
  input wire logic rc,
  input wire logic [3:0] channel_number,
  output var logic [`IOCSS_BUS_W-1:0] exchange_bus_line_out,
  output var logic [`IOCSS_BUS_W-1:0] exchange_bus_line_oe,
  input wire logic device_is_output,
  input wire logic fixed_record,
  input wire logic op_done,
  input wire logic next_is_last,
  input wire logic more_buffers,
  input wire logic [15:0] tx_word,
  output var logic tx_taken,
  output var logic rx_valid,
  output var logic [15:0] rx_word,
  output var logic [4:0] rx_state,
  output var logic service_request,
  output var logic [4:0] sequence_state_count
);

  // synchronised pins
  logic [`IOCSS_SYNC_W-1:0] sync_q;
  logic [`IOCSS_BUS_W-1:0] bus_s; // exchange lines
  logic pha_s; // phase a
  logic phb_s; // phase b
  logic rc_s; // remove-data strobe
  logic [3:0] chan_s; // channel jumper

  iocss_sync2 u_sync (
    .clk(clk),
    .rst(rst),
    .d({exchange_bus_line_in, phase_a, phase_b, rc, channel_number}),
    .q(sync_q)
  );

  assign bus_s = sync_q[`IOCSS_SYNC_W-1:`IOCSS_SYNC_BUS_LSB];
  assign pha_s = sync_q[`IOCSS_SYNC_PHA];
  assign phb_s = sync_q[`IOCSS_SYNC_PHB];
  assign rc_s = sync_q[`IOCSS_SYNC_RC];
  assign chan_s = sync_q[`IOCSS_SYNC_CHAN_MSB:`IOCSS_SYNC_CHAN_LSB];

  // edge history of the synchronised strobes
  logic pha_d_reg;
  logic phb_d_reg;
  logic rc_d_reg;
  logic pha_rise; // phase a begins
  logic phb_rise; // phase b begins
  logic phb_fall; // phase b ends, exchange done
  logic rc_rise; // processor says remove data

  assign pha_rise = pha_s & ~pha_d_reg;
  assign phb_rise = phb_s & ~phb_d_reg;
  assign phb_fall = ~phb_s & phb_d_reg;
  assign rc_rise = rc_s & ~rc_d_reg;

  // phase a word, held until the next phase a
  logic [`IOCSS_BUS_W-1:0] cmd_reg;
  logic [3:0] basic; // basic command field
  logic [3:0] variant; // control variant field
  logic [3:0] cmd_chan; // addressed channel
  logic addressed; // this control is the target

  assign basic = cmd_reg[`IOCSS_CMD_MSB:`IOCSS_CMD_LSB];
  assign variant = cmd_reg[`IOCSS_VAR_MSB:`IOCSS_VAR_LSB];
  assign cmd_chan = cmd_reg[`IOCSS_CHAN_MSB:`IOCSS_CHAN_LSB];
  assign addressed = (cmd_chan == chan_s);

  // command decode
  logic is_xout_a; // data rides in the phase a word
  logic is_xout_b; // data rides in phase b
  logic is_xout;
  logic is_xin;
  logic is_var;
  logic v_test;
  logic v_clear;
  logic v_poll;
  logic v_term;

  assign is_xout_a = (basic == `IOCSS_BASIC_XOUT_A);
  assign is_xout_b = (basic == `IOCSS_BASIC_XOUT_B);
  assign is_xout = is_xout_a | is_xout_b;
  assign is_xin = (basic == `IOCSS_BASIC_XIN);
  assign is_var = (basic == `IOCSS_BASIC_VARIANT);
  // variant bits count only under the variant basic code
  assign v_test = is_var & (variant == `IOCSS_VAR_TEST);
  assign v_clear = is_var & (variant == `IOCSS_VAR_CLEAR);
  assign v_poll = is_var & (variant == `IOCSS_VAR_POLL);
  assign v_term = is_var & (variant == `IOCSS_VAR_TERM);

  // sequence state
  iocss_state_t state_reg;
  iocss_state_t state_next;
  logic srq_reg; // service request pending

  // direction of the current state
  logic st_last; // one of the two last-byte states
  logic st_rx; // processor sends to the control
  logic st_tx; // control sends to the processor
  logic st_data; // any data state

  assign st_last = (state_reg == IOCSS_ST_LAST_LOAD) | (state_reg == IOCSS_ST_LAST_FINAL);
  // opcode, file and reference address bytes come
  assign st_rx = ((state_reg >= IOCSS_ST_READY) & (state_reg <= IOCSS_ST_RA_IN3))
               | (state_reg == IOCSS_ST_DATA_RX)
               | (st_last & device_is_output);
  // reference address, data and result bytes go out
  assign st_tx = ((state_reg >= IOCSS_ST_RA_DX1) & (state_reg <= IOCSS_ST_RA_DX3))
               | (state_reg == IOCSS_ST_DATA_TX)
               | ((state_reg >= IOCSS_ST_RA_RD1) & (state_reg <= IOCSS_ST_RD3))
               | (st_last & ~device_is_output);
  assign st_data = (state_reg == IOCSS_ST_DATA_RX) | (state_reg == IOCSS_ST_DATA_TX) | st_last;

  // a byte moves only on an own-channel exchange of the right direction
  logic xfer_ok;
  logic done_w; // exchange that moves a byte has just ended
  logic clear_w; // clear and test status has just ended
  logic term_w; // terminate data accepted

  assign xfer_ok = addressed & ((is_xout & st_rx) | (is_xin & st_tx));
  assign done_w = phb_fall & xfer_ok;
  assign clear_w = phb_fall & addressed & v_clear;
  // terminate data only means something to variable-length devices
  assign term_w = phb_fall & addressed & v_term & ~fixed_record & st_data;

  // reply word for phase b
  logic drive_w; // this control answers in phase b
  logic [`IOCSS_BUS_W-1:0] reply_w;
  logic [`IOCSS_BUS_W-1:0] reply_oe_w;
  logic [`IOCSS_BUS_W-1:0] poll_bit_w;

  // poll answer sits on the bit numbered as the channel
  assign poll_bit_w = `IOCSS_ONE_BIT << chan_s;
  assign drive_w = (addressed & (is_xin | v_test | v_clear)) | (v_poll & srq_reg);
  // transfer in carries data plus the five status bits
  assign reply_w = v_poll ? poll_bit_w
                 : is_xin ? {`IOCSS_PAD3, state_reg, tx_word}
                 : {`IOCSS_PAD3, state_reg, `IOCSS_PAD10, CTRL_ID};
  // a poll reply drives only its own line so other controls can share the bus
  assign reply_oe_w = v_poll ? poll_bit_w : `IOCSS_ALL_ON;

  // received data word, depending on which transfer-out form was used
  logic [15:0] rx_data_w;
  assign rx_data_w = is_xout_a ? cmd_reg[`IOCSS_DATA_MSB:`IOCSS_DATA_LSB]
                   : bus_s[`IOCSS_DATA_MSB:`IOCSS_DATA_LSB];

  // next state; clear wins over all, then terminate data, then bytes
  always_comb begin
    state_next = state_reg;
    if (clear_w) begin
      state_next = IOCSS_ST_NOT_READY;
    end else if (term_w) begin
      state_next = IOCSS_ST_RA_RD1;
    end else begin
      case (state_reg)
        IOCSS_ST_NOT_READY: begin
          state_next = IOCSS_ST_READY;
        end
        IOCSS_ST_BUSY: begin
          // completion of the operation leads to the data path
          if (op_done) begin
            state_next = IOCSS_ST_RA_DX1;
          end
        end
        IOCSS_ST_RA_IN3: begin
          if (done_w) begin
            state_next = IOCSS_ST_BUSY;
          end
        end
        IOCSS_ST_RA_DX3: begin
          // same device class always picks the same branch
          if (done_w) begin
            state_next = device_is_output ? IOCSS_ST_DATA_RX : IOCSS_ST_DATA_TX;
          end
        end
        IOCSS_ST_DATA_RX, IOCSS_ST_DATA_TX: begin
          // stay in the data state until the next byte is the last one
          if (done_w & next_is_last) begin
            state_next = more_buffers ? IOCSS_ST_LAST_LOAD : IOCSS_ST_LAST_FINAL;
          end
        end
        IOCSS_ST_LAST_LOAD: begin
          // another buffer load follows; go busy while it is fetched
          if (done_w) begin
            state_next = IOCSS_ST_BUSY;
          end
        end
        IOCSS_ST_LAST_FINAL: begin
          if (done_w) begin
            state_next = IOCSS_ST_RA_RD1;
          end
        end
        IOCSS_ST_RD3: begin
          // result byte three closes the sequence
          if (done_w) begin
            state_next = IOCSS_ST_NOT_READY;
          end
        end
        default: begin
          // plain one-step states: opcode, addresses, result bytes
          if (done_w) begin
            state_next = iocss_state_t'(state_reg + `IOCSS_STEP);
          end
        end
      endcase
    end
  end

  // service request: set on completion, cleared by an own-channel exchange other than a poll
  logic srq_set;
  logic srq_clr;
  logic srq_next;

  assign srq_set = (state_reg == IOCSS_ST_BUSY) & op_done & ~clear_w;
  assign srq_clr = phb_fall & addressed & ~v_poll;
  // set wins over clear so a completion is lost only when a clear and test ends in the same cycle
  assign srq_next = srq_set | (srq_reg & ~srq_clr);

  // bus drive: on at phase b start, off on rc or the end of phase b
  logic [`IOCSS_BUS_W-1:0] out_reg;
  logic [`IOCSS_BUS_W-1:0] oe_reg;
  logic [`IOCSS_BUS_W-1:0] out_next;
  logic [`IOCSS_BUS_W-1:0] oe_next;

  assign out_next = (phb_rise & drive_w) ? reply_w : (rc_rise | phb_fall) ? `IOCSS_ALL_OFF : out_reg;
  assign oe_next = (phb_rise & drive_w) ? reply_oe_w : (rc_rise | phb_fall) ? `IOCSS_ALL_OFF : oe_reg;

  // strobe history and command latch
  always_ff @(posedge clk) begin
    if (rst) begin
      pha_d_reg <= 1'b0;
      phb_d_reg <= 1'b0;
      rc_d_reg <= 1'b0;
      cmd_reg <= `IOCSS_ALL_OFF;
    end else begin
      pha_d_reg <= pha_s;
      phb_d_reg <= phb_s;
      rc_d_reg <= rc_s;
      if (pha_rise) begin
        cmd_reg <= bus_s;
      end
    end
  end

  // state count and service request
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= IOCSS_ST_NOT_READY;
      srq_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      srq_reg <= srq_next;
    end
  end

  // bus drivers
  always_ff @(posedge clk) begin
    if (rst) begin
      out_reg <= `IOCSS_ALL_OFF;
      oe_reg <= `IOCSS_ALL_OFF;
    end else begin
      out_reg <= out_next;
      oe_reg <= oe_next;
    end
  end

  // user-side strobes; rx_word keeps its last value between bytes
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_valid <= 1'b0;
      tx_taken <= 1'b0;
      rx_word <= 16'h0000;
      rx_state <= 5'h00;
    end else begin
      rx_valid <= done_w & is_xout;
      tx_taken <= done_w & is_xin;
      if (done_w & is_xout) begin
        rx_word <= rx_data_w;
        rx_state <= state_reg;
      end
    end
  end

  assign exchange_bus_line_out = out_reg;
  assign exchange_bus_line_oe = oe_reg;
  assign service_request = srq_reg;
  assign sequence_state_count = state_reg;
  // checks
  sequence s_done_in(iocss_state_t st);
    done_w && !clear_w && (state_reg == st);
  endsequence
  sequence s_restart;
    (state_reg == IOCSS_ST_NOT_READY) ##1 (state_reg == IOCSS_ST_READY);
  endsequence
  // a clear that ends while the count is zero holds it there one cycle more
  a_zero_to_ready: assert property (@(posedge clk) disable iff (rst)
    (state_reg == IOCSS_ST_NOT_READY) && !clear_w |=> (state_reg == IOCSS_ST_READY))
    else $error("not ready did not move to ready");
  a_opcode_step: assert property (@(posedge clk) disable iff (rst)
    s_done_in(IOCSS_ST_READY) |=> (state_reg == IOCSS_ST_OP2))
    else $error("first opcode byte did not advance");
  a_file_addr: assert property (@(posedge clk) disable iff (rst)
    s_done_in(IOCSS_ST_FA3) |=> (state_reg == IOCSS_ST_RA_IN1))
    else $error("file address did not lead to reference address");
  a_busy_entry: assert property (@(posedge clk) disable iff (rst)
    s_done_in(IOCSS_ST_RA_IN3) |=> (state_reg == IOCSS_ST_BUSY) && !tx_taken)
    else $error("instructions accepted but not busy");
  a_busy_srq: assert property (@(posedge clk) disable iff (rst)
    (state_reg == IOCSS_ST_BUSY) && op_done && !clear_w |=> srq_reg && (state_reg == IOCSS_ST_RA_DX1))
    else $error("completion did not raise service request");
  a_result_end: assert property (@(posedge clk) disable iff (rst)
    s_done_in(IOCSS_ST_RD3) |=> s_restart)
    else $error("result byte three did not restart sequence");
  a_clear_reset: assert property (@(posedge clk) disable iff (rst)
    clear_w |=> (state_reg == IOCSS_ST_NOT_READY) ##1 (state_reg == IOCSS_ST_READY))
    else $error("clear and test did not reset control");
  a_hold_unaddr: assert property (@(posedge clk) disable iff (rst)
    !done_w && !clear_w && !term_w && (state_reg != IOCSS_ST_BUSY) && (state_reg != IOCSS_ST_NOT_READY)
    |=> $stable(state_reg))
    else $error("state moved without own exchange");
  a_poll_bit: assert property (@(posedge clk) disable iff (rst)
    phb_rise && v_poll && srq_reg |=> (oe_reg == (`IOCSS_ONE_BIT << chan_s)) && out_reg[chan_s])
    else $error("poll reply not on own channel bit");
  a_test_reply: assert property (@(posedge clk) disable iff (rst)
    phb_rise && addressed && v_test |=> (out_reg[`IOCSS_STAT_MSB:`IOCSS_STAT_LSB] == $past(state_reg))
    && (out_reg[`IOCSS_ID_MSB:`IOCSS_ID_LSB] == CTRL_ID))
    else $error("test status reply wrong");
  a_xin_data: assert property (@(posedge clk) disable iff (rst)
    phb_rise && addressed && is_xin |=> (out_reg[`IOCSS_DATA_MSB:`IOCSS_DATA_LSB] == $past(tx_word))
    && (oe_reg == `IOCSS_ALL_ON))
    else $error("transfer in reply wrong");
endmodule // iocss_sequencer

`default_nettype wire

// ===== rtl/iocss_defs.svh
`ifndef IOCSS_DEFS_SVH
`define IOCSS_DEFS_SVH

// exchange word layout, phase A
`define IOCSS_BUS_W 24
`define IOCSS_CMD_MSB 23
`define IOCSS_CMD_LSB 20
`define IOCSS_CHAN_MSB 19
`define IOCSS_CHAN_LSB 16
`define IOCSS_VAR_MSB 3
`define IOCSS_VAR_LSB 0
`define IOCSS_DATA_MSB 15
`define IOCSS_DATA_LSB 0

// basic command codes
`define IOCSS_BASIC_XOUT_A 4'h2
`define IOCSS_BASIC_XOUT_B 4'h3
`define IOCSS_BASIC_XIN 4'h4
`define IOCSS_BASIC_VARIANT 4'h1

// control variant codes
`define IOCSS_VAR_TEST 4'h1
`define IOCSS_VAR_CLEAR 4'h3
`define IOCSS_VAR_POLL 4'h5
`define IOCSS_VAR_TERM 4'h6

// reply word pieces
`define IOCSS_PAD3 3'h0
`define IOCSS_PAD10 10'h000
`define IOCSS_ONE_BIT 24'h00_0001
`define IOCSS_ALL_ON 24'hFF_FFFF
`define IOCSS_ALL_OFF 24'h00_0000
`define IOCSS_STEP 5'h01

// width of the synchroniser bank: bus, phase a, phase b, rc, channel
`define IOCSS_SYNC_W 31
// positions inside the synchroniser bank
`define IOCSS_SYNC_BUS_LSB 7
`define IOCSS_SYNC_PHA 6
`define IOCSS_SYNC_PHB 5
`define IOCSS_SYNC_RC 4
`define IOCSS_SYNC_CHAN_MSB 3
`define IOCSS_SYNC_CHAN_LSB 0

// reply word fields
`define IOCSS_STAT_MSB 20
`define IOCSS_STAT_LSB 16
`define IOCSS_ID_MSB 5
`define IOCSS_ID_LSB 0

`endif

// ===== rtl/iocss_pkg.sv
package iocss_pkg;

  // sequence state count, the five status bits
  typedef enum logic [4:0] {
    IOCSS_ST_NOT_READY = 5'b00000,
    IOCSS_ST_READY = 5'b00001,
    IOCSS_ST_OP2 = 5'b00010,
    IOCSS_ST_OP3 = 5'b00011,
    IOCSS_ST_FA1 = 5'b00100,
    IOCSS_ST_FA2 = 5'b00101,
    IOCSS_ST_FA3 = 5'b00110,
    IOCSS_ST_RA_IN1 = 5'b00111,
    IOCSS_ST_RA_IN2 = 5'b01000,
    IOCSS_ST_RA_IN3 = 5'b01001,
    IOCSS_ST_BUSY = 5'b01010,
    IOCSS_ST_RA_DX1 = 5'b01011,
    IOCSS_ST_RA_DX2 = 5'b01100,
    IOCSS_ST_RA_DX3 = 5'b01101,
    IOCSS_ST_DATA_RX = 5'b01110,
    IOCSS_ST_DATA_TX = 5'b01111,
    IOCSS_ST_LAST_LOAD = 5'b10000,
    IOCSS_ST_LAST_FINAL = 5'b10001,
    IOCSS_ST_RA_RD1 = 5'b10010,
    IOCSS_ST_RA_RD2 = 5'b10011,
    IOCSS_ST_RA_RD3 = 5'b10100,
    IOCSS_ST_RD1 = 5'b10101,
    IOCSS_ST_RD2 = 5'b10110,
    IOCSS_ST_RD3 = 5'b10111
  } iocss_state_t;

endpackage

// ===== rtl/iocss_sync2.sv
`timescale 1ns/1ns
`default_nettype none
`include "iocss_defs.svh"

// two-flop synchroniser bank for every pin that the control samples
module iocss_sync2 (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`IOCSS_SYNC_W-1:0] d,
  output var logic [`IOCSS_SYNC_W-1:0] q
);

  // first stage, read by the second stage only
  logic [`IOCSS_SYNC_W-1:0] meta_reg;

  // both stages clear to zero; the pins are idle low
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule // iocss_sync2

`default_nettype wire

// ===== rtl/iocss_sync2_unused_guard.sv
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ===== sim/iocss_host.sv
`timescale 1ns/1ns
`default_nettype none
`include "iocss_defs.svh"

// processor side of the shared exchange bus; every strobe moves just after a falling edge
module iocss_host (
  input wire logic clk,
  input wire logic [23:0] bus_wire,
  output var logic phase_a,
  output var logic phase_b,
  output var logic rc,
  output var logic drv,
  output var logic [23:0] host_word
);
  // idle: no strobe, bus released
  initial begin
    phase_a = 1'b0;
    phase_b = 1'b0;
    rc = 1'b0;
    drv = 1'b0;
    host_word = 24'h00_0000;
  end

  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask

  // command word held through phase a; 4 cycles keeps above the 3-cycle minimum
  task automatic cmd_phase(input logic [23:0] w);
    @(negedge clk);
    host_word = w;
    drv = 1'b1;
    phase_a = 1'b1;
    gap(4);
    phase_a = 1'b0;
    gap(4);
  endtask

  // transfer out: word stays on the bus until phase b has fallen
  task automatic xout(input logic [23:0] w);
    cmd_phase(w);
    phase_b = 1'b1;
    gap(4);
    phase_b = 1'b0;
    gap(4);
    drv = 1'b0;
  endtask

  // transfer in: bus released, reply read, then rc tells the control to let go
  task automatic xin(input logic [23:0] w, output logic [23:0] r);
    cmd_phase(w);
    drv = 1'b0;
    phase_b = 1'b1;
    gap(6);
    r = bus_wire;
    rc = 1'b1;
    gap(4);
    phase_b = 1'b0;
    rc = 1'b0;
    gap(5);
  endtask
endmodule // iocss_host

`default_nettype wire

// ===== sim/io_control_state_sequencer_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "iocss_defs.svh"

module io_control_state_sequencer_bench;
  localparam logic [3:0] CH = 4'h2; // own channel; poll word bit 2 is set, so a released line 2 reads low
  localparam logic [5:0] ID = 6'h15; // identification, value is arbitrary
  logic clk, rst, op_done, next_is_last, more_buffers, is_out, fixed, pa, pb, rc, drv;
  logic tx_taken, rx_valid, sreq;
  logic [15:0] tx_word, rx_word;
  logic [23:0] out, oe, bus_wire, host_word;
  logic [4:0] rx_state, state;
  int n_errors = 0;
  int checks = 0;
  int n_rx = 0; // rx_valid pulses seen
  int n_tx = 0; // tx_taken pulses seen

  // each pulse stands one cycle, so exactly one falling edge sees it
  always @(negedge clk) begin
    if (rx_valid === 1'b1) n_rx++;
    if (tx_taken === 1'b1) n_tx++;
  end

  // released lines show the host's word while drv is set and its inverse once the host lets go, never a stale copy
  assign bus_wire = (out & oe) | (~oe & (drv ? host_word : ~host_word));

  iocss_sequencer #(.CTRL_ID(ID)) dut (
    .clk(clk), .rst(rst), .exchange_bus_line_in(bus_wire), .phase_a(pa), .phase_b(pb),
    .rc(rc), .channel_number(CH), .exchange_bus_line_out(out), .exchange_bus_line_oe(oe),
    .device_is_output(is_out), .fixed_record(fixed), .op_done(op_done),
    .next_is_last(next_is_last), .more_buffers(more_buffers), .tx_word(tx_word),
    .tx_taken(tx_taken), .rx_valid(rx_valid), .rx_word(rx_word), .rx_state(rx_state),
    .service_request(sreq), .sequence_state_count(state)
  );

  iocss_host host (
    .clk(clk), .bus_wire(bus_wire), .phase_a(pa), .phase_b(pb), .rc(rc), .drv(drv),
    .host_word(host_word)
  );

  // 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic logic [23:0] word(input logic [3:0] b, input logic [15:0] d);
    return {b, CH, d};
  endfunction

  // one transfer out, then the state it must land in
  task automatic xo(input logic [3:0] b, input logic [15:0] d, input logic [4:0] s_exp);
    int r0;
    r0 = n_rx;
    host.xout(word(b, d));
    chk("state", 24'(s_exp), 24'(state));
    chk("rx pulses", 24'(b != `IOCSS_BASIC_VARIANT), 24'(n_rx - r0));
  endtask

  // one transfer in: reply is status in 20:16 over the offered word
  task automatic xi(input logic [4:0] s_exp);
    logic [23:0] r;
    logic [4:0] s0;
    int t0;
    s0 = state;
    t0 = n_tx;
    tx_word = {s0, 11'h5A3};
    host.xin(word(`IOCSS_BASIC_XIN, 16'h0000), r);
    chk("reply", {3'h0, s0, s0, 11'h5A3}, r);
    chk("state", 24'(s_exp), 24'(state));
    chk("tx pulses", 24'h00_0001, 24'(n_tx - t0));
  endtask

  task automatic poll(input logic exp);
    logic [23:0] r;
    int t0;
    t0 = n_tx;
    host.xin(word(`IOCSS_BASIC_VARIANT, {12'h000, `IOCSS_VAR_POLL}), r);
    chk("poll bit", 24'(exp), 24'(r[CH]));
    chk("poll tx pulses", 24'h00_0000, 24'(n_tx - t0));
  endtask

  task automatic t_reset;
    chk("state in reset", 24'h00_0000, 24'(state));
    rst = 1'b0;
    repeat (5) @(negedge clk);
    chk("state after reset", 24'h00_0001, 24'(state));
    $display("test reset done");
  endtask

  // nine bytes in; low nibble 3 must not act as a clear outside a variant command
  task automatic t_open;
    host.xout({`IOCSS_BASIC_XOUT_A, CH + 4'h1, 16'h1234});
    chk("other channel", 24'h00_0001, 24'(state));
    for (int i = 0; i < 9; i++) begin
      xo(i[0] ? `IOCSS_BASIC_XOUT_B : `IOCSS_BASIC_XOUT_A, {4'(i), 12'hA03}, 5'(i + 2));
      chk("rx word", {8'h00, 4'(i), 12'hA03}, 24'(rx_word));
      chk("rx state", 24'(i + 1), 24'(rx_state));
    end
    $display("test opening done");
  endtask

  // busy holds until completion, which raises a service request
  task automatic t_busy;
    repeat (6) @(negedge clk);
    chk("busy", 24'h00_000A, 24'(state));
    op_done = 1'b1;
    @(negedge clk);
    op_done = 1'b0;
    repeat (4) @(negedge clk);
    chk("after busy", 24'h00_000B, 24'(state));
    chk("request", 24'h00_0001, 24'(sreq));
    poll(1'b1);
    $display("test busy done");
  endtask

  task automatic t_refs(input logic [4:0] last);
    xi(5'h0C);
    poll(1'b0);
    xi(5'h0D);
    xi(last);
    $display("test reference done");
  endtask

  task automatic t_results;
    for (int i = 0; i < 5; i++)
      xi(5'(19 + i));
    xi(5'h01);
    $display("test results done");
  endtask

  // output device: one load with more to follow, busy again, then the final load
  task automatic t_data_out;
    next_is_last = 1'b1;
    more_buffers = 1'b1;
    xo(`IOCSS_BASIC_XOUT_A, 16'hBEEF, 5'h10);
    chk("data word", 24'h00_BEEF, 24'(rx_word));
    xo(`IOCSS_BASIC_XOUT_B, 16'h0042, 5'h0A);
    t_busy();
    t_refs(5'h0E);
    // a fixed-length device ignores terminate data
    xo(`IOCSS_BASIC_VARIANT, {12'h000, `IOCSS_VAR_TERM}, 5'h0E);
    more_buffers = 1'b0;
    xo(`IOCSS_BASIC_XOUT_A, 16'h7701, 5'h11);
    xo(`IOCSS_BASIC_XOUT_A, 16'h7702, 5'h12);
    $display("test output data done");
  endtask

  // status test leaves the count alone; clear reports it, then resets the control
  task automatic t_clear;
    logic [23:0] r;
    for (int i = 0; i < 3; i++)
      xo(`IOCSS_BASIC_XOUT_A, 16'h0100, 5'(i + 2));
    host.xin(word(`IOCSS_BASIC_VARIANT, {12'h000, `IOCSS_VAR_TEST}), r);
    chk("test reply", {3'h0, 5'h04, 10'h000, ID}, r);
    chk("state", 24'h00_0004, 24'(state));
    host.xin(word(`IOCSS_BASIC_VARIANT, {12'h000, `IOCSS_VAR_CLEAR}), r);
    chk("clear reply", {3'h0, 5'h04, 10'h000, ID}, r);
    chk("state", 24'h00_0001, 24'(state));
    $display("test clear done");
  endtask

  // variable-length input device: one byte out, then terminate data
  task automatic t_input;
    is_out = 1'b0;
    fixed = 1'b0;
    next_is_last = 1'b0;
    t_open();
    t_busy();
    t_refs(5'h0F);
    xi(5'h0F);
    xo(`IOCSS_BASIC_VARIANT, {12'h000, `IOCSS_VAR_TERM}, 5'h12);
    t_results();
    $display("test input done");
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    $display("wrong value run length expected finish seen hang");
    complete_run();
  end

  initial begin
    rst = 1'b1;
    op_done = 1'b0;
    next_is_last = 1'b0;
    more_buffers = 1'b0;
    is_out = 1'b1;
    fixed = 1'b1;
    tx_word = 16'h0000;
    repeat (12) @(negedge clk);
    t_reset();
    t_open();
    t_busy();
    t_refs(5'h0E);
    t_data_out();
    t_results();
    t_clear();
    t_input();
    complete_run();
  end
endmodule // io_control_state_sequencer_bench

`default_nettype wire
